// file: design/ist_timing_seq.sv
/*
 Instruction state timing sequencer: takes an instruction class, works out
 its cycle counts by type and its state total, and holds busy for that many
 clocks. Assumes start and its qualifiers come from logic on ref_clk.
*/
`timescale 1ns/1ps
module ist_timing_seq (
   input  wire logic                                       ref_clk,
   input  wire logic                                       rst,
   input  wire logic                                       start,
   input  wire logic [ist_pkg::OP_W-1:0]                   opSel,
   input  wire logic [ist_pkg::NTYPES*ist_pkg::CNT_W-1:0]  explicitCounts,
   input  wire logic                                       byteToPeriph,
   input  wire logic                                       periphSlow,
   input  wire logic                                       wordToPeriph,
   output logic                                            busy,
   output logic                                            done,
   output logic [ist_pkg::TOT_W-1:0]                       stateTotal,
   output logic [ist_pkg::NTYPES*ist_pkg::CNT_W-1:0]       typeCounts
);
   typedef struct packed {
      ist_pkg::ist_state_t          state;
      logic                         busy;
      logic                         done;
      logic [ist_pkg::TOT_W-1:0]    remain;
      logic [ist_pkg::TOT_W-1:0]    total;
      ist_pkg::ist_counts_t         counts;
   } ist_regs_t;

   ist_regs_t  r_q;
   ist_regs_t  r_d;
   ist_cost_if costBus ();

   // Counts of the requested instruction feed the calculator
   assign costBus.counts       = ist_pkg::ist_op_counts(opSel, explicitCounts);
   assign costBus.byteToPeriph = byteToPeriph;
   assign costBus.periphSlow   = periphSlow;
   assign costBus.wordToPeriph = wordToPeriph;

   ist_cost_calc uCalc (
      .c (costBus.calc)
   );

   // Next state
   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;
      case (r_q.state)
         ist_pkg::IST_IDLE: begin
            if (start) begin
               r_d.counts = costBus.counts;
               r_d.total  = costBus.total;
               r_d.remain = costBus.total;
               if (costBus.total == ist_pkg::RST_TOTAL) begin
                  r_d.done = 1'b1;
               end else begin
                  r_d.state = ist_pkg::IST_RUN;
                  r_d.busy  = 1'b1;
               end
            end
         end
         ist_pkg::IST_RUN: begin
            // One state per clock until the total has elapsed
            r_d.remain = ist_pkg::TOT_W'(r_q.remain - 1'b1);
            if (r_q.remain == ist_pkg::TOT_W'(1)) begin
               r_d.state = ist_pkg::IST_IDLE;
               r_d.busy  = 1'b0;
               r_d.done  = 1'b1;
            end
         end
         default: begin
            r_d.state = ist_pkg::IST_IDLE;
            r_d.busy  = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_q.state  <= ist_pkg::IST_IDLE;
         r_q.busy   <= 1'b0;
         r_q.done   <= 1'b0;
         r_q.remain <= ist_pkg::RST_TOTAL;
         r_q.total  <= ist_pkg::RST_TOTAL;
         r_q.counts <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the state register
   assign busy       = r_q.busy;
   assign done       = r_q.done;
   assign stateTotal = r_q.total;
   assign typeCounts = r_q.counts;
endmodule // ist_timing_seq

// file: design/ist_pkg.sv
/*
 Constants, instruction classes and cycle-count table for the instruction
 state timing sequencer. Assumes one core clock where one state equals one
 clock period.
*/
// What this block does
// - Total states is the sum of each cycle count times its per-cycle state cost.
// - Cycle counts are kept separately for each of the six cycle types.
// - An on-chip memory instruction fetch cycle costs exactly two states.
// - An internal operation cycle costs exactly one state, wherever the access goes.
// - A byte access to a peripheral costs two or three states, by module.
// - Word sum and conjunction need two fetches with immediate, one register form.
// - Longword sum and conjunction with immediate need three fetch cycles.
// - Address increment by 1, 2 or 4 needs one fetch cycle only.
// - Bit set at absolute address needs two fetch and two byte cycles.
// - Indirect subroutine call needs two fetches, one branch read, one stack cycle.
// - On-chip branch address reads and stack operations cost two states each.
package ist_pkg;
   localparam int unsigned NTYPES = 6;
   localparam int unsigned CNT_W  = 4;
   localparam int unsigned TOT_W  = 9;
   localparam int unsigned COST_W = 2;
   localparam int unsigned OP_W   = 5;

   // Position of each cycle type in a counts vector
   localparam int TY_FETCH    = 0;
   localparam int TY_BRANCH   = 1;
   localparam int TY_STACK    = 2;
   localparam int TY_BYTE     = 3;
   localparam int TY_WORD     = 4;
   localparam int TY_INTERNAL = 5;

   // States per cycle
   localparam logic [COST_W-1:0] ST_ONCHIP      = 2'h2;
   localparam logic [COST_W-1:0] ST_INTERNAL    = 2'h1;
   localparam logic [COST_W-1:0] ST_PERIPH_FAST = 2'h2;
   localparam logic [COST_W-1:0] ST_PERIPH_SLOW = 2'h3;
   localparam logic [COST_W-1:0] ST_WORD_PERIPH = 2'h2;

   // Values after reset
   localparam logic [TOT_W-1:0] RST_TOTAL = 9'h000;

   // Instruction classes
   localparam logic [OP_W-1:0] OP_SUM_B_IMM   = 5'h00;
   localparam logic [OP_W-1:0] OP_SUM_B_REG   = 5'h01;
   localparam logic [OP_W-1:0] OP_SUM_W_IMM   = 5'h02;
   localparam logic [OP_W-1:0] OP_SUM_W_REG   = 5'h03;
   localparam logic [OP_W-1:0] OP_SUM_L_IMM   = 5'h04;
   localparam logic [OP_W-1:0] OP_SUM_L_REG   = 5'h05;
   localparam logic [OP_W-1:0] OP_ADDR_INC    = 5'h06;
   localparam logic [OP_W-1:0] OP_CARRY_IMM   = 5'h07;
   localparam logic [OP_W-1:0] OP_CARRY_REG   = 5'h08;
   localparam logic [OP_W-1:0] OP_AND_B_IMM   = 5'h09;
   localparam logic [OP_W-1:0] OP_AND_B_REG   = 5'h0A;
   localparam logic [OP_W-1:0] OP_AND_W_IMM   = 5'h0B;
   localparam logic [OP_W-1:0] OP_AND_W_REG   = 5'h0C;
   localparam logic [OP_W-1:0] OP_AND_L_IMM   = 5'h0D;
   localparam logic [OP_W-1:0] OP_AND_L_REG   = 5'h0E;
   localparam logic [OP_W-1:0] OP_BIT_SET_ABS = 5'h0F;
   localparam logic [OP_W-1:0] OP_CALL_IND    = 5'h10;
   localparam logic [OP_W-1:0] OP_EXPLICIT    = 5'h1F;

   typedef logic [NTYPES-1:0][CNT_W-1:0] ist_counts_t;

   typedef enum logic [0:0] {IST_IDLE, IST_RUN} ist_state_t;

   // Cycle counts of one instruction class; unknown classes take the given counts
   function automatic ist_counts_t ist_op_counts(input logic [OP_W-1:0] op,
                                                 input ist_counts_t explicitCnt);
      ist_counts_t c;
      c = '0;
      case (op)
         OP_SUM_B_IMM, OP_SUM_B_REG: c[TY_FETCH] = 4'h1;
         OP_AND_B_IMM, OP_AND_B_REG: c[TY_FETCH] = 4'h1;
         OP_SUM_W_IMM, OP_AND_W_IMM: c[TY_FETCH] = 4'h2;
         OP_SUM_W_REG, OP_AND_W_REG: c[TY_FETCH] = 4'h1;
         OP_SUM_L_IMM, OP_AND_L_IMM: c[TY_FETCH] = 4'h3;
         OP_AND_L_REG:               c[TY_FETCH] = 4'h2;
         OP_SUM_L_REG:               c[TY_FETCH] = 4'h1;
         OP_ADDR_INC:                c[TY_FETCH] = 4'h1;
         OP_CARRY_IMM, OP_CARRY_REG: c[TY_FETCH] = 4'h1;
         OP_BIT_SET_ABS: begin
            c[TY_FETCH] = 4'h2;
            c[TY_BYTE]  = 4'h2;
         end
         OP_CALL_IND: begin
            c[TY_FETCH]  = 4'h2;
            c[TY_BRANCH] = 4'h1;
            c[TY_STACK]  = 4'h1;
         end
         default: c = explicitCnt;
      endcase
      return c;
   endfunction
endpackage

// file: design/ist_cost_if.sv
/*
 Carrier between the sequencer and its state-cost calculator.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface ist_cost_if;
   ist_pkg::ist_counts_t          counts;
   logic                          byteToPeriph;
   logic                          periphSlow;
   logic                          wordToPeriph;
   logic [ist_pkg::TOT_W-1:0]     total;

   modport calc (input counts, input byteToPeriph, input periphSlow, input wordToPeriph,
                 output total);
   modport user (output counts, output byteToPeriph, output periphSlow,
                 output wordToPeriph, input total);
endinterface

// file: design/ist_cost_calc.sv
/*
 Combinational sum of cycle counts times per-cycle state cost.
 Assumes counts and access locations are stable while they are used.
*/
`timescale 1ns/1ps
module ist_cost_calc (
   ist_cost_if.calc c
);
   logic [ist_pkg::NTYPES-1:0][ist_pkg::TOT_W-1:0] part;

   // States per cycle of one type, by access location
   function automatic logic [ist_pkg::COST_W-1:0] cost_of(input int ty, input logic toPer,
                                                          input logic slow, input logic wPer);
      logic [ist_pkg::COST_W-1:0] s;
      s = ist_pkg::ST_ONCHIP;
      if (ty == ist_pkg::TY_INTERNAL) begin
         s = ist_pkg::ST_INTERNAL;
      end else if (ty == ist_pkg::TY_BYTE && toPer) begin
         s = slow ? ist_pkg::ST_PERIPH_SLOW : ist_pkg::ST_PERIPH_FAST;
      end else if (ty == ist_pkg::TY_WORD && wPer) begin
         s = ist_pkg::ST_WORD_PERIPH;
      end
      return s;
   endfunction

   // One product per cycle type
   genvar g;
   generate
      for (g = 0; g < ist_pkg::NTYPES; g++) begin : gProd
         assign part[g] = ist_pkg::TOT_W'(c.counts[g] *
                          cost_of(g, c.byteToPeriph, c.periphSlow, c.wordToPeriph));
      end
   endgenerate

   // Sum of the products
   always_comb begin
      logic [ist_pkg::TOT_W-1:0] acc;
      acc = '0;
      for (int i = 0; i < ist_pkg::NTYPES; i++) begin
         acc = ist_pkg::TOT_W'(acc + part[i]);
      end
      c.total = acc;
   end
endmodule // ist_cost_calc

// file: test/ist_periph_model.sv
/* Peripheral side model: tells the sequencer how slow the addressed module is.
 Assumes modSel names one of four on-chip peripheral modules. */
`timescale 1ns/1ps
module ist_periph_model (
   input  wire logic [1:0] modSel,
   output logic            periphSlow
);
   // Upper two modules need three states per byte access
   assign periphSlow = modSel[1];
endmodule // ist_periph_model

// file: test/ist_timing_assertions.sv
/* Port checker for the instruction state timing sequencer.
 Assumes one clock ref_clk and synchronous active-high rst. */
`timescale 1ns/1ps
module ist_timing_checker (
   input wire logic                                      ref_clk,
   input wire logic                                      rst,
   input wire logic                                      start,
   input wire logic [ist_pkg::OP_W-1:0]                  opSel,
   input wire logic [ist_pkg::NTYPES*ist_pkg::CNT_W-1:0] explicitCounts,
   input wire logic                                      byteToPeriph,
   input wire logic                                      periphSlow,
   input wire logic                                      busy,
   input wire logic                                      done,
   input wire logic [ist_pkg::TOT_W-1:0]                 stateTotal
);
   logic [8:0] runCnt_q;
   logic       acc;
   // Count busy cycles of the current instruction
   always_ff @(posedge ref_clk) runCnt_q <= busy ? runCnt_q + 9'h001 : 9'h000;
   assign acc = start && !busy;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_reset_clear: assert property (disable iff (1'b0) rst |=> !busy && !done && stateTotal == 9'h000)
      else $error("reset state wrong");
   a_bitset_total: assert property (acc && opSel == ist_pkg::OP_BIT_SET_ABS && !byteToPeriph
      |=> busy && stateTotal == 9'h008) else $error("bit set total wrong");
   a_call_total: assert property (acc && opSel == ist_pkg::OP_CALL_IND |=> stateTotal == 9'h008)
      else $error("call total wrong");
   a_long_fetch: assert property (acc && opSel == ist_pkg::OP_SUM_L_IMM |=> stateTotal == 9'h006)
      else $error("long sum total wrong");
   a_slow_byte: assert property (acc && opSel == ist_pkg::OP_BIT_SET_ABS && byteToPeriph
      && periphSlow |=> stateTotal == 9'h00A) else $error("slow byte total wrong");
   a_internal_cost: assert property (acc && opSel == ist_pkg::OP_EXPLICIT
      && explicitCounts == 24'h310000 |=> stateTotal == 9'h005) else $error("internal cost wrong");
   a_busy_length: assert property ($fell(busy) && !$past(rst) |-> runCnt_q == stateTotal)
      else $error("busy length wrong");
   a_done_end: assert property ($fell(busy) && !$past(rst) |-> done) else $error("done missing");
   a_busy_ignore: assert property (busy && start |=> $stable(stateTotal))
      else $error("start taken while busy");
   c_slow: cover property (acc && byteToPeriph && periphSlow);
   c_refused: cover property (busy && start);
   c_finish: cover property (done);
endmodule // ist_timing_checker

bind ist_timing_seq ist_timing_checker u_chk (.ref_clk(ref_clk), .rst(rst), .start(start),
   .opSel(opSel), .explicitCounts(explicitCounts), .byteToPeriph(byteToPeriph),
   .periphSlow(periphSlow), .busy(busy), .done(done), .stateTotal(stateTotal));

// file: test/tb.sv
/* Self-checking bench for the instruction state timing sequencer.
 Assumes the peripheral model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb;
   logic        ref_clk = 1'b0, rst = 1'b1, start = 1'b0;
   logic        byteToPeriph = 1'b0, wordToPeriph = 1'b0, periphSlow, busy, done;
   logic [1:0]  modSel = 2'h0;
   logic [4:0]  opSel = 5'h00;
   logic [23:0] explicitCounts = 24'h000000, typeCounts;
   logic [8:0]  stateTotal;
   int          err_count = 0, num_checks = 0, cyc = 0;
   always #4 ref_clk = ~ref_clk;
   ist_periph_model u_mod (.modSel(modSel), .periphSlow(periphSlow));
   ist_timing_seq u_dut (.ref_clk(ref_clk), .rst(rst), .start(start), .opSel(opSel),
      .explicitCounts(explicitCounts), .byteToPeriph(byteToPeriph), .periphSlow(periphSlow),
      .wordToPeriph(wordToPeriph), .busy(busy), .done(done), .stateTotal(stateTotal),
      .typeCounts(typeCounts));
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h got %h", nm, exp, got);
      end
   endtask
   // One instruction: take it, check totals, time busy, optionally poke start meanwhile
   task automatic issue(input logic [4:0] op, input logic [23:0] ex, input logic bp,
                        input logic [1:0] ms, input logic [8:0] expT, input logic [23:0] expC,
                        input bit poke);
      int n;
      n = 0;
      @(posedge ref_clk);
      start <= 1'b1;
      opSel <= op;
      explicitCounts <= ex;
      byteToPeriph <= bp;
      modSel <= ms;
      @(posedge ref_clk);
      start <= 1'b0;
      #1;
      chk("stateTotal", {15'h0, expT}, {15'h0, stateTotal});
      chk("typeCounts", expC, typeCounts);
      while (busy === 1'b1 && n < 400) begin
         @(posedge ref_clk);
         if (poke) start <= (n == 0);
         #1;
         n++;
      end
      chk("busyCycles", {15'h0, expT}, n[23:0]);
      chk("done", 24'h1, {23'h0, done});
      chk("totalHeld", {15'h0, expT}, {15'h0, stateTotal});
   endtask
   task automatic t_sums;
      logic [3:0] f [15];
      f = '{4'h1, 4'h1, 4'h2, 4'h1, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h3, 4'h2};
      for (int i = 0; i < 15; i++) begin
         issue(i[4:0], 24'h0, 1'b0, 2'h0, {4'h0, f[i], 1'b0}, {20'h0, f[i]}, 0);
      end
      $display("Sum and conjunction classes done");
   endtask
   task automatic t_bitset;
      issue(ist_pkg::OP_BIT_SET_ABS, 24'h0, 1'b0, 2'h0, 9'h008, 24'h002002, 0);
      $display("Bit set done");
   endtask
   task automatic t_call;
      issue(ist_pkg::OP_CALL_IND, 24'h0, 1'b0, 2'h0, 9'h008, 24'h000112, 1);
      $display("Indirect call with refused start done");
   endtask
   task automatic t_periph;
      issue(ist_pkg::OP_BIT_SET_ABS, 24'h0, 1'b1, 2'h1, 9'h008, 24'h002002, 0);
      issue(ist_pkg::OP_BIT_SET_ABS, 24'h0, 1'b1, 2'h3, 9'h00A, 24'h002002, 0);
      $display("Peripheral byte access done");
   endtask
   task automatic t_explicit;
      @(posedge ref_clk);
      wordToPeriph <= 1'b1;
      issue(ist_pkg::OP_EXPLICIT, 24'h310000, 1'b0, 2'h0, 9'h005, 24'h310000, 0);
      issue(ist_pkg::OP_EXPLICIT, 24'h000000, 1'b0, 2'h0, 9'h000, 24'h000000, 0);
      issue(ist_pkg::OP_EXPLICIT, 24'h111111, 1'b0, 2'h0, 9'h00B, 24'h111111, 0);
      $display("Explicit counts done");
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_sums;
      t_bitset;
      t_call;
      t_periph;
      t_explicit;
      report_and_stop;
   end
endmodule // tb
